// >>> hdl/stc_pkg.sv
package stc_pkg;
  // register map
  localparam logic [7:0] CTRL_ADDR = 8'h10;
  localparam logic [7:0] CNT_LO_ADDR = 8'h0e;
  localparam logic [7:0] CNT_HI_ADDR = 8'h0f;
  localparam logic [7:0] FLAG_ADDR = 8'h0c;
  localparam logic [7:0] IRQEN_ADDR = 8'h8c;
  // control field positions
  localparam int ON_BIT = 0;
  localparam int CS_BIT = 1;
  localparam int SYNC_BIT = 2;
  localparam int OSC_BIT = 3;
  localparam int PS_LO = 4;
  localparam logic [7:0] CTRL_MASK = 8'h3f;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int OVF_BIT = 0;
  // instruction cycle is four oscillator periods
  localparam int CLK_MHZ = 100;
  localparam int FOSC_MHZ = 20;
  localparam int INSTR_DIV = (CLK_MHZ * 4) / FOSC_MHZ;
  localparam logic [7:0] INSTR_DIV_M1 = 8'(INSTR_DIV - 1);

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } stc_bus_s;

  typedef enum logic [1:0] {
    PS_1 = 2'b00,
    PS_2 = 2'b01,
    PS_4 = 2'b10,
    PS_8 = 2'b11
  } stc_ps_e;
endpackage

// >>> hdl/stc_prescaler.sv
`timescale 1ns/1ps
// ripple-style prescaler run on synchronised edges; 3-bit counter
module stc_prescaler (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic clr,
  input wire logic edge_in,
  input wire stc_pkg::stc_ps_e sel,
  // output tick
  output logic tick
);
  logic [2:0] cnt_q;

  always_ff @(posedge clk)
  begin
    if (rst || clr)
      cnt_q <= 3'h0;
    else if (edge_in)
      cnt_q <= cnt_q + 3'h1;
  end

  always_comb
  begin
    unique case (sel)
      stc_pkg::PS_1: tick = edge_in;
      stc_pkg::PS_2: tick = edge_in && (cnt_q[0] == 1'b1);
      stc_pkg::PS_4: tick = edge_in && (cnt_q[1:0] == 2'h3);
      stc_pkg::PS_8: tick = edge_in && (cnt_q == 3'h7);
    endcase
  end
endmodule

// >>> hdl/stc_timer.sv
`timescale 1ns/1ps
module stc_timer (
  // clock and resets
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic POR_RST,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // pins
  input wire logic OSC_INPUT_PIN,
  input wire logic EXT_COUNT_INPUT_PIN,
  input wire logic [1:0] PORT_DIRECTION,
  output logic [1:0] PIN_OE,
  output logic OSC_RUN,
  // system
  input wire logic SLEEP,
  input wire logic [1:0] CAPTURE_COMPARE_TRIGGER,
  output logic IRQ,
  output logic WAKE,
  output logic TIMEBASE_VALID,
  output logic [15:0] COUNT
);
  stc_pkg::stc_bus_s bus;
  logic [7:0] ctrl_q;
  logic [7:0] cnt_lo_q;
  logic [7:0] cnt_hi_q;
  logic ovf_q;
  logic irqen_q;
  logic [7:0] div_q;
  logic instr_en;
  logic [2:0] osc_sync_q;
  logic [2:0] ext_sync_q;
  logic pin_edge;
  logic src_edge;
  logic ps_tick;
  logic inc;
  logic wrap;
  logic cnt_wr;
  logic trig;
  logic async_mode;

  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
  assign async_mode = ctrl_q[stc_pkg::CS_BIT] && ctrl_q[stc_pkg::SYNC_BIT];
  assign cnt_wr = bus.wr && (bus.addr == stc_pkg::CNT_LO_ADDR || bus.addr == stc_pkg::CNT_HI_ADDR);
  assign trig = |CAPTURE_COMPARE_TRIGGER;

  // instruction-cycle enable from a divider
  always_ff @(posedge CLOCK)
  begin
    if (RST || div_q == stc_pkg::INSTR_DIV_M1)
      div_q <= 8'h00;
    else
      div_q <= div_q + 8'h01;
  end
  assign instr_en = (div_q == stc_pkg::INSTR_DIV_M1);

  // pins pass two flops; the third stage only feeds edge detection
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      osc_sync_q <= 3'h0;
      ext_sync_q <= 3'h0;
    end
    else
    begin
      osc_sync_q <= {osc_sync_q[1:0], OSC_INPUT_PIN};
      ext_sync_q <= {ext_sync_q[1:0], EXT_COUNT_INPUT_PIN};
    end
  end

  // oscillator pin when crystal enabled, else dedicated input
  assign pin_edge = ctrl_q[stc_pkg::OSC_BIT] ? (osc_sync_q[1] && !osc_sync_q[2])
                                              : (ext_sync_q[1] && !ext_sync_q[2]);
  // internal clock ignores the sync bit
  assign src_edge = ctrl_q[stc_pkg::CS_BIT] ? pin_edge : instr_en;

  // prescaler sees edges even in sleep; only count writes and reset clear it
  stc_prescaler u_ps (
    .clk(CLOCK),
    .rst(RST),
    .clr(cnt_wr),
    .edge_in(src_edge && ctrl_q[stc_pkg::ON_BIT]),
    .sel(stc_pkg::stc_ps_e'(ctrl_q[stc_pkg::PS_LO +: 2])),
    .tick(ps_tick)
  );

  // synchronised path is gated off in sleep; async path keeps going
  assign inc = ps_tick && ctrl_q[stc_pkg::ON_BIT] && (async_mode || !SLEEP);
  assign wrap = inc && ({cnt_hi_q, cnt_lo_q} == 16'hffff);

  // control register: only the full reset clears it
  always_ff @(posedge CLOCK)
  begin
    if (POR_RST)
      ctrl_q <= stc_pkg::CTRL_RESET;
    else if (bus.wr && bus.addr == stc_pkg::CTRL_ADDR)
      ctrl_q <= bus.wdata & stc_pkg::CTRL_MASK;
  end

  // count bytes have no reset; write beats trigger beats increment
  always_ff @(posedge CLOCK)
  begin
    if (bus.wr && bus.addr == stc_pkg::CNT_LO_ADDR)
      cnt_lo_q <= bus.wdata;
    else if (trig && !async_mode && !cnt_wr)
      cnt_lo_q <= 8'h00;
    else if (inc)
      cnt_lo_q <= cnt_lo_q + 8'h01;
    if (bus.wr && bus.addr == stc_pkg::CNT_HI_ADDR)
      cnt_hi_q <= bus.wdata;
    else if (bus.wr && bus.addr == stc_pkg::CNT_LO_ADDR)
      cnt_hi_q <= cnt_hi_q;
    else if (trig && !async_mode)
      cnt_hi_q <= 8'h00;
    else if (inc && cnt_lo_q == 8'hff)
      cnt_hi_q <= cnt_hi_q + 8'h01;
  end

  // sticky flag; set beats a clearing write, trigger never sets it
  always_ff @(posedge CLOCK)
  begin
    if (POR_RST)
      ovf_q <= 1'b0;
    else if (wrap && !cnt_wr && !(trig && !async_mode))
      ovf_q <= 1'b1;
    else if (bus.wr && bus.addr == stc_pkg::FLAG_ADDR && !bus.wdata[stc_pkg::OVF_BIT])
      ovf_q <= 1'b0;
  end

  always_ff @(posedge CLOCK)
  begin
    if (POR_RST)
      irqen_q <= 1'b0;
    else if (bus.wr && bus.addr == stc_pkg::IRQEN_ADDR)
      irqen_q <= bus.wdata[stc_pkg::OVF_BIT];
  end

  // registered outputs
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      IRQ <= 1'b0;
      WAKE <= 1'b0;
      PIN_OE <= 2'b00;
      OSC_RUN <= 1'b0;
      TIMEBASE_VALID <= 1'b0;
      COUNT <= 16'h0000;
    end
    else
    begin
      IRQ <= ovf_q && irqen_q;
      WAKE <= ovf_q && irqen_q && async_mode && SLEEP;
      // port direction bit 1 means input, as on the port
      PIN_OE <= ctrl_q[stc_pkg::OSC_BIT] ? 2'b00 : ~PORT_DIRECTION;
      OSC_RUN <= ctrl_q[stc_pkg::OSC_BIT];
      TIMEBASE_VALID <= !async_mode;
      COUNT <= {cnt_hi_q, cnt_lo_q};
    end
  end

  // count held in core-clock flops, so reads never tear a byte
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      RDATA <= 8'h00;
    else if (bus.rd)
    begin
      unique case (bus.addr)
        stc_pkg::CTRL_ADDR: RDATA <= ctrl_q & stc_pkg::CTRL_MASK;
        stc_pkg::CNT_LO_ADDR: RDATA <= cnt_lo_q;
        stc_pkg::CNT_HI_ADDR: RDATA <= cnt_hi_q;
        stc_pkg::FLAG_ADDR: RDATA <= {7'h00, ovf_q};
        stc_pkg::IRQEN_ADDR: RDATA <= {7'h00, irqen_q};
        default: RDATA <= 8'h00;
      endcase
    end
    else
      RDATA <= 8'h00;
  end

  // assertions
  sequence s_wrap;
    wrap && !cnt_wr && !(trig && !async_mode);
  endsequence

  property p_wrap_zero;
    @(posedge CLOCK) disable iff (RST) s_wrap |=> ({cnt_hi_q, cnt_lo_q} == 16'h0000);
  endproperty
  a_wrap_zero: assert property (p_wrap_zero) else $error("count did not wrap to zero");

  property p_flag_set;
    @(posedge CLOCK) disable iff (RST || POR_RST) s_wrap |=> ovf_q;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("overflow flag not set");

  property p_irq;
    @(posedge CLOCK) disable iff (RST) IRQ |-> $past(irqen_q);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt while disabled");

  property p_stopped;
    @(posedge CLOCK) disable iff (RST) (!ctrl_q[stc_pkg::ON_BIT] && !cnt_wr && !trig) |=> $stable(cnt_lo_q);
  endproperty
  a_stopped: assert property (p_stopped) else $error("count moved while stopped");

  property p_ctrl_read;
    @(posedge CLOCK) disable iff (RST) (bus.rd && bus.addr == stc_pkg::CTRL_ADDR) |=> (RDATA[7:6] == 2'b00);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("unimplemented bits read one");

  property p_pins_in;
    @(posedge CLOCK) disable iff (RST) ctrl_q[stc_pkg::OSC_BIT] |=> (PIN_OE == 2'b00);
  endproperty
  a_pins_in: assert property (p_pins_in) else $error("pins driven with oscillator on");

  property p_sleep_sync;
    @(posedge CLOCK) disable iff (RST) (SLEEP && !async_mode && !cnt_wr && !trig) |=> $stable(cnt_lo_q);
  endproperty
  a_sleep_sync: assert property (p_sleep_sync) else $error("synced count moved in sleep");

  property p_trig_clear;
    @(posedge CLOCK) disable iff (RST) (trig && !async_mode && !cnt_wr) |=> ({cnt_hi_q, cnt_lo_q} == 16'h0000) && !$rose(ovf_q);
  endproperty
  a_trig_clear: assert property (p_trig_clear) else $error("trigger did not clear count");

  property p_write_wins;
    @(posedge CLOCK) disable iff (RST) (bus.wr && bus.addr == stc_pkg::CNT_LO_ADDR) |=> (cnt_lo_q == $past(bus.wdata));
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("count write lost");

  property p_flag_hold;
    @(posedge CLOCK) disable iff (RST || POR_RST)
      (ovf_q && !(bus.wr && bus.addr == stc_pkg::FLAG_ADDR)) |=> ovf_q;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag cleared by hardware");

  property p_timebase;
    @(posedge CLOCK) disable iff (RST) async_mode |=> !TIMEBASE_VALID;
  endproperty
  a_timebase: assert property (p_timebase) else $error("time base offered in async mode");

  localparam int INSTR_GAP = stc_pkg::INSTR_DIV;

  property p_instr_gap;
    @(posedge CLOCK) disable iff (RST) instr_en |-> ##[INSTR_GAP:INSTR_GAP] instr_en;
  endproperty
  a_instr_gap: assert property (p_instr_gap) else $error("instruction enable period wrong");

  property p_timer_tick;
    @(posedge CLOCK) disable iff (RST) (!ctrl_q[stc_pkg::CS_BIT] && ps_tick) |-> instr_en;
  endproperty
  a_timer_tick: assert property (p_timer_tick) else $error("timer tick off the instruction cycle");

  property p_osc_pick;
    @(posedge CLOCK) disable iff (RST) (ctrl_q[stc_pkg::CS_BIT] && ctrl_q[stc_pkg::OSC_BIT] && src_edge) |-> $rose(osc_sync_q[1]);
  endproperty
  a_osc_pick: assert property (p_osc_pick) else $error("counted edge not from osc pin");

  property p_ext_pick;
    @(posedge CLOCK) disable iff (RST) (ctrl_q[stc_pkg::CS_BIT] && !ctrl_q[stc_pkg::OSC_BIT] && src_edge) |-> $rose(ext_sync_q[1]);
  endproperty
  a_ext_pick: assert property (p_ext_pick) else $error("counted edge not from count pin");

  property p_irq_level;
    @(posedge CLOCK) disable iff (RST) !RST |=> (IRQ == $past(ovf_q && irqen_q));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

  property p_wake;
    @(posedge CLOCK) disable iff (RST) !RST |=> (WAKE == $past(ovf_q && irqen_q && async_mode && SLEEP));
  endproperty
  a_wake: assert property (p_wake) else $error("wake level wrong");

  property p_async_sleep;
    @(posedge CLOCK) disable iff (RST) (SLEEP && async_mode && ps_tick && !cnt_wr) |=> (cnt_lo_q == $past(cnt_lo_q) + 8'h01);
  endproperty
  a_async_sleep: assert property (p_async_sleep) else $error("async count stalled in sleep");

  property p_ps_sleep;
    @(posedge CLOCK) disable iff (RST) (SLEEP && ctrl_q[stc_pkg::ON_BIT] && src_edge && !cnt_wr) |=> (u_ps.cnt_q == $past(u_ps.cnt_q) + 3'h1);
  endproperty
  a_ps_sleep: assert property (p_ps_sleep) else $error("prescaler stalled in sleep");

  property p_ps_clear;
    @(posedge CLOCK) disable iff (RST) cnt_wr |=> (u_ps.cnt_q == 3'h0);
  endproperty
  a_ps_clear: assert property (p_ps_clear) else $error("count write left prescaler");

  property p_ctrl_por;
    @(posedge CLOCK) POR_RST |=> (ctrl_q == stc_pkg::CTRL_RESET);
  endproperty
  a_ctrl_por: assert property (p_ctrl_por) else $error("power-on reset left control");

  property p_ctrl_keep;
    @(posedge CLOCK) (RST && !POR_RST && !bus.wr) |=> $stable(ctrl_q);
  endproperty
  a_ctrl_keep: assert property (p_ctrl_keep) else $error("plain reset changed control");

  property p_flag_clear;
    @(posedge CLOCK) disable iff (POR_RST)
      (bus.wr && bus.addr == stc_pkg::FLAG_ADDR && !bus.wdata[stc_pkg::OVF_BIT] && !wrap) |=> !ovf_q;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag survived clearing write");

  property p_osc_run;
    @(posedge CLOCK) disable iff (RST) !RST |=> (OSC_RUN == $past(ctrl_q[stc_pkg::OSC_BIT]));
  endproperty
  a_osc_run: assert property (p_osc_run) else $error("oscillator run level wrong");

  property p_pin_dir;
    @(posedge CLOCK) disable iff (RST) !ctrl_q[stc_pkg::OSC_BIT] |=> (PIN_OE == ~$past(PORT_DIRECTION));
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("pin enable ignores port direction");

  // a read is a request, one data cycle, then zero again
  sequence s_lo_read;
    bus.rd && bus.addr == stc_pkg::CNT_LO_ADDR;
  endsequence

  property p_lo_read;
    @(posedge CLOCK) disable iff (RST) s_lo_read |=> (RDATA == $past(cnt_lo_q));
  endproperty
  a_lo_read: assert property (p_lo_read) else $error("low byte read wrong");

  property p_lo_read_end;
    @(posedge CLOCK) disable iff (RST) s_lo_read ##1 !bus.rd |=> (RDATA == 8'h00);
  endproperty
  a_lo_read_end: assert property (p_lo_read_end) else $error("read data stood too long");

  property p_hi_read;
    @(posedge CLOCK) disable iff (RST) (bus.rd && bus.addr == stc_pkg::CNT_HI_ADDR) |=> (RDATA == $past(cnt_hi_q));
  endproperty
  a_hi_read: assert property (p_hi_read) else $error("high byte read wrong");
endmodule

// >>> test/stc_clk_src.sv
`timescale 1ns/1ps
// far-side clock source: crystal on the osc pin or a clock on the count pin
module stc_clk_src (
  // core clock for pacing
  input wire logic clk,
  // pins
  output logic osc_pin,
  output logic ext_pin
);
  initial
  begin
    osc_pin = 1'b0;
    ext_pin = 1'b0;
  end
  // pulses slow enough for the two-flop synchroniser to see every edge
  task automatic burst(input int n, input bit on_osc);
    repeat (n)
    begin
      @(posedge clk);
      if (on_osc) osc_pin <= 1'b1;
      else ext_pin <= 1'b1;
      repeat (6) @(posedge clk);
      osc_pin <= 1'b0;
      ext_pin <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask
endmodule

// >>> test/tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
  logic clock, rst, por_rst, wr, rd, sleep;
  logic [7:0] addr, wdata, rdata, v;
  logic [1:0] trig, pin_oe, port_dir;
  logic osc_run, irq, wake, tb_valid, osc_pin, ext_pin;
  logic [15:0] count, c0;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  stc_timer u_dut (.CLOCK(clock), .RST(rst), .POR_RST(por_rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .OSC_INPUT_PIN(osc_pin), .EXT_COUNT_INPUT_PIN(ext_pin),
    .PORT_DIRECTION(port_dir), .PIN_OE(pin_oe), .OSC_RUN(osc_run), .SLEEP(sleep), .CAPTURE_COMPARE_TRIGGER(trig),
    .IRQ(irq), .WAKE(wake), .TIMEBASE_VALID(tb_valid), .COUNT(count));
  stc_clk_src u_src (.clk(clock), .osc_pin(osc_pin), .ext_pin(ext_pin));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic finish_test();
    if (error_cnt == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // hang guard, generous against the longest sequence
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // stop first, then load: writes never race an increment
  task automatic load(input logic [15:0] c);
    wreg(stc_pkg::CTRL_ADDR, 8'h00);
    wreg(stc_pkg::CNT_LO_ADDR, c[7:0]);
    wreg(stc_pkg::CNT_HI_ADDR, c[15:8]);
  endtask
  initial
  begin
    {rst, por_rst} = 2'b11;
    {addr, wdata, wr, rd, sleep, trig, port_dir} = '0;
    // count has no reset; load it under reset so no check sees it unknown
    repeat (4) @(posedge clock);
    wreg(stc_pkg::CNT_LO_ADDR, 8'h00);
    wreg(stc_pkg::CNT_HI_ADDR, 8'h00);
    {rst, por_rst} <= 2'b00;
    rreg(stc_pkg::CTRL_ADDR, v); `CHK(v, 8'h00)
    `CHK(pin_oe, 2'b11)
    port_dir <= 2'b01;
    repeat (2) @(posedge clock);
    `CHK(pin_oe, 2'b10)
    wreg(stc_pkg::CTRL_ADDR, 8'hf0);
    rreg(stc_pkg::CTRL_ADDR, v); `CHK(v, 8'h30)
    @(posedge clock) rst <= 1'b1;
    @(posedge clock) rst <= 1'b0;
    rreg(stc_pkg::CTRL_ADDR, v); `CHK(v, 8'h30)
    rreg(8'h55, v); `CHK(v, 8'h00)
    load(16'hfffe);
    rreg(stc_pkg::CNT_LO_ADDR, v); `CHK(v, 8'hfe)
    wreg(stc_pkg::CTRL_ADDR, 8'h01);
    for (int i = 0; i < 100 && count !== 16'h0000; i++) @(posedge clock);
    `CHK(count, 16'h0000)
    rreg(stc_pkg::FLAG_ADDR, v); `CHK(v[0], 1'b1)
    `CHK(irq, 1'b0)
    wreg(stc_pkg::IRQEN_ADDR, 8'h01);
    repeat (2) @(posedge clock);
    `CHK(irq, 1'b1)
    `CHK(wake, 1'b0)
    wreg(stc_pkg::FLAG_ADDR, 8'h00);
    repeat (2) @(posedge clock);
    `CHK(irq, 1'b0)
    wreg(stc_pkg::CTRL_ADDR, 8'h00);
    repeat (3) @(posedge clock);
    c0 = count;
    repeat (60) @(posedge clock);
    `CHK(count, c0)
    for (int p = 0; p < 4; p++)
    begin
      load(16'h0000);
      wreg(stc_pkg::CTRL_ADDR, 8'(p << 4) | 8'h03);
      u_src.burst(8, 1'b0);
      repeat (10) @(posedge clock);
      `CHK(count, 16'(8 >> p))
    end
    // one edge leaves the 1:2 prescaler half way; a count write must empty it
    load(16'h0000);
    wreg(stc_pkg::CTRL_ADDR, 8'h13);
    u_src.burst(1, 1'b0);
    load(16'h0000);
    wreg(stc_pkg::CTRL_ADDR, 8'h13);
    u_src.burst(1, 1'b0);
    repeat (10) @(posedge clock);
    `CHK(count, 16'h0000)
    for (int t = 0; t < 2; t++)
    begin
      load(16'h1234);
      @(posedge clock) trig <= 2'(1 << t);
      @(posedge clock) trig <= 2'b00;
      repeat (3) @(posedge clock);
      `CHK(count, 16'h0000)
      rreg(stc_pkg::FLAG_ADDR, v); `CHK(v[0], 1'b0)
    end
    load(16'h1234);
    @(posedge clock);
    {addr, wdata, wr, trig} <= {stc_pkg::CNT_LO_ADDR, 8'h5a, 1'b1, 2'b01};
    @(posedge clock);
    {addr, wdata, wr, trig} <= {stc_pkg::CNT_HI_ADDR, 8'h77, 1'b1, 2'b10};
    @(posedge clock);
    {wr, trig} <= 3'b000;
    repeat (3) @(posedge clock);
    `CHK(count, 16'h775a)
    wreg(stc_pkg::CTRL_ADDR, 8'h08);
    repeat (50) @(posedge clock);
    `CHK(osc_run, 1'b1)
    `CHK(pin_oe, 2'b00)
    wreg(stc_pkg::CNT_LO_ADDR, 8'h00);
    wreg(stc_pkg::CNT_HI_ADDR, 8'h00);
    wreg(stc_pkg::CTRL_ADDR, 8'h0b);
    u_src.burst(5, 1'b1);
    u_src.burst(3, 1'b0);
    repeat (10) @(posedge clock);
    `CHK(count, 16'h0005)
    `CHK(tb_valid, 1'b1)
    load(16'h0010);
    wreg(stc_pkg::CTRL_ADDR, 8'h13);
    sleep <= 1'b1;
    u_src.burst(3, 1'b0);
    repeat (10) @(posedge clock);
    `CHK(count, 16'h0010)
    sleep <= 1'b0;
    // prescaler kept counting asleep, so one more edge ticks at 1:2
    u_src.burst(1, 1'b0);
    repeat (10) @(posedge clock);
    `CHK(count, 16'h0011)
    load(16'hffff);
    wreg(stc_pkg::CTRL_ADDR, 8'h07);
    sleep <= 1'b1;
    u_src.burst(1, 1'b0);
    repeat (10) @(posedge clock);
    `CHK(count, 16'h0000)
    `CHK(wake, 1'b1)
    `CHK(tb_valid, 1'b0)
    finish_test();
  end
endmodule
